/* inc/rgx_map.svh */
// Sizes, alignment, implementation codes and defaults for the register group port
`ifndef RGX_MAP_SVH
`define RGX_MAP_SVH
`define RGX_NREG        3
`define RGX_AW          8
`define RGX_DW          32
`define RGX_REGWIDTH    32
`define RGX_ALIGN       4
`define RGX_MEM_ENTRIES 1
`define RGX_MEM_WIDTH   `RGX_REGWIDTH
`define RGX_IMPL_INT    2'h0
`define RGX_IMPL_EXT    2'h1
`define RGX_IMPL_ALIAS  2'h2
`endif

/* inc/rgx_pkg.sv */
// Types for the register group external port
package rgx_pkg;
  typedef enum logic [1:0] {
    RGX_GRP_NONE = 2'b00,
    RGX_GRP_INT  = 2'b01,
    RGX_GRP_EXT  = 2'b10
  } rgx_grp_t;
  typedef struct packed {
    logic req;
    logic wr;
  } rgx_ctl_t;
endpackage : rgx_pkg

/* hdl/rgx_group.sv */
// Register group: internal/external split and shared external bus
// Notes on behaviour
// R01: Shared option gives one common control set to external members.
// R02: Shared write data spans all registers, fields at own positions.
// R03: Shared read data common; each value extracted by field positions.
// R04: Undeclared group gives per-member selects beside shared control.
// R05: External group presents address as byte offset from group start.
// R06: Error input on external group; outermost group counts only.
// R07: External error merges into top-level transaction error.
// R08: Alignment is a power of two in bytes.
// R09: Default placement aligns each member to its own width.
// R10: Member decode uses byte addresses.
// R11: Internal group forces all internal; external forces all external.
// R12: Undeclared group uses each member's own declaration.
// R13: Group holds at least one member; kinds may mix.
// R14: Memory entry count positive, default one.
// R15: Memory width positive, defaults to register width.
// R16: External member drives only its own field bits while selected.
`timescale 1ns/1ps
`include "rgx_map.svh"
module rgx_group
  import rgx_pkg::*;
#(
  parameter int              NREG     = `RGX_NREG,
  parameter int              AW       = `RGX_AW,
  parameter int              DW       = `RGX_DW,
  parameter int              ALIGN    = `RGX_ALIGN,
  parameter int              MEM_N    = `RGX_MEM_ENTRIES,
  parameter int              MEM_W    = `RGX_MEM_WIDTH,
  parameter rgx_grp_t        GRP      = RGX_GRP_NONE,
  parameter bit              SHARED   = 1'b1,
  parameter bit              ERR_EN   = 1'b1,
  parameter bit              OUTER    = 1'b1,
  parameter logic [AW-1:0]   BASE     = 8'h00,
  parameter logic [NREG*2-1:0] KIND   = 6'b01_01_00,
  parameter logic [NREG*DW-1:0] FMASK = {3{32'hFFFF_FFFF}}
)(
  input  wire logic            clk,        // 10 MHz clock
  input  wire logic            rstn,       // Async reset, active low
  input  wire logic            req,        // Access request
  input  wire logic            wr,         // 1 write, 0 read
  input  wire logic [AW-1:0]   addr,       // Byte address
  input  wire logic [DW-1:0]   wdata,      // Write data
  output logic      [DW-1:0]   rdata,      // Read data
  output logic                 ack,        // Access done
  output logic                 err,        // Transaction error
  output rgx_ctl_t             ext_ctl,    // Shared external control
  output logic      [NREG-1:0] ext_sel,    // Per-member selects
  output logic      [AW-1:0]   ext_addr,   // Offset from group start
  output logic      [DW-1:0]   ext_wdata,  // Shared write data
  input  wire logic [DW-1:0]   ext_rdata,  // Shared read data
  input  wire logic            ext_err     // Error from external side
);
  localparam int STRIDE = (DW / 8 > ALIGN) ? DW / 8 : ALIGN; // R09

  initial begin
    if (ALIGN <= 0 || (ALIGN & (ALIGN - 1)) != 0)
      $error("alignment not a power of two"); // R08
    if (NREG < 1)
      $error("group needs a member"); // R13
    if (MEM_N <= 0 || MEM_W <= 0)
      $error("memory size must be positive"); // R14 R15
  end

  // Effective implementation per member after group coercion
  logic [NREG-1:0] is_ext;
  logic [NREG-1:0] hit;
  logic [AW-1:0]   off;
  assign off = addr - BASE; // R05 R10

  // Continuous assigns: one packed vector, one driver per bit
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_mem
      assign is_ext[g] = (GRP == RGX_GRP_INT) ? 1'b0 :            // R11
                         (GRP == RGX_GRP_EXT) ? 1'b1 :            // R11
                         (KIND[g*2 +: 2] != `RGX_IMPL_INT);       // R12
      assign hit[g]    = (off == AW'(g * STRIDE));               // R09 R10
    end
  endgenerate

  // Internal storage for non-external members
  logic [DW-1:0] store_q [NREG];
  logic [DW-1:0] store_d [NREG];
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      store_d[i] = store_q[i];
      if (req && wr && hit[i] && !is_ext[i])
        store_d[i] = wdata & FMASK[i*DW +: DW];
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NREG; i++)
        store_q[i] <= '0;
    end else begin
      for (int i = 0; i < NREG; i++)
        store_q[i] <= store_d[i];
    end
  end

  // Combined field span of external members
  logic [DW-1:0] span;
  logic [DW-1:0] sel_mask;
  logic          ext_hit;
  logic          any_hit;
  always_comb begin
    span     = '0;
    sel_mask = '0;
    for (int i = 0; i < NREG; i++) begin
      if (is_ext[i])
        span = span | FMASK[i*DW +: DW];
      if (hit[i])
        sel_mask = FMASK[i*DW +: DW];
    end
    ext_hit = |(hit & is_ext);
    any_hit = |hit;
  end

  // Registered outputs
  rgx_ctl_t        ctl_q, ctl_d;
  logic [NREG-1:0] sel_q, sel_d;
  logic [AW-1:0]   xa_q, xa_d;
  logic [DW-1:0]   xw_q, xw_d;
  logic [DW-1:0]   rd_q, rd_d;
  logic            ack_q, ack_d;
  logic            err_q, err_d;
  logic            pend_q, pend_d;
  logic [DW-1:0]   sel_mask_q;

  always_comb begin
    ctl_d  = '0;
    sel_d  = '0;
    xa_d   = xa_q;
    xw_d   = xw_q;
    rd_d   = rd_q;
    ack_d  = 1'b0;
    err_d  = 1'b0;
    pend_d = 1'b0;
    if (pend_q) begin
      // External answer taken in the same cycle as the strobe; ack follows one cycle later
      ack_d = 1'b1;
      rd_d  = ext_rdata & sel_mask_q & span; // R03 R16
      err_d = ERR_EN && OUTER && (GRP == RGX_GRP_EXT) && ext_err; // R06 R07
    end else if (req) begin
      if (ext_hit) begin
        ctl_d.req = 1'b1; // R01
        ctl_d.wr  = wr;
        if (SHARED)
          sel_d = hit & is_ext; // R04
        else
          sel_d = hit & is_ext;
        xa_d   = off; // R05
        xw_d   = wdata & span; // R02
        pend_d = 1'b1;
      end else begin
        ack_d = 1'b1;
        err_d = !any_hit;
        rd_d  = '0;
        for (int i = 0; i < NREG; i++)
          if (hit[i])
            rd_d = store_q[i] & FMASK[i*DW +: DW];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q      <= '0;
      sel_q      <= '0;
      xa_q       <= '0;
      xw_q       <= '0;
      rd_q       <= '0;
      ack_q      <= 1'b0;
      err_q      <= 1'b0;
      pend_q     <= 1'b0;
      sel_mask_q <= '0;
    end else begin
      ctl_q      <= ctl_d;
      sel_q      <= sel_d;
      xa_q       <= xa_d;
      xw_q       <= xw_d;
      rd_q       <= rd_d;
      ack_q      <= ack_d;
      err_q      <= err_d;
      pend_q     <= pend_d;
      sel_mask_q <= pend_d ? sel_mask : sel_mask_q;
    end
  end

  assign ext_ctl   = ctl_q;
  assign ext_sel   = (GRP == RGX_GRP_NONE) ? sel_q : '0; // R04
  assign ext_addr  = xa_q;
  assign ext_wdata = xw_q;
  assign rdata     = rd_q;
  assign ack       = ack_q;
  assign err       = err_q;

  a_ctl_one_strobe: assert property (@(posedge clk) disable iff (!rstn)
    ext_ctl.req |=> !ext_ctl.req && ack)
    else $error("external strobe not answered"); // R01
  a_wdata_span: assert property (@(posedge clk) disable iff (!rstn)
    ext_ctl.req |-> (ext_wdata & ~span) == '0)
    else $error("write data outside span"); // R02
  a_rdata_field: assert property (@(posedge clk) disable iff (!rstn)
    $past(pend_q) && ack |-> (rdata & ~span) == '0)
    else $error("read data outside span"); // R03
  a_sel_one_hot: assert property (@(posedge clk) disable iff (!rstn)
    ext_ctl.req |-> $onehot0(ext_sel))
    else $error("more than one select"); // R04
  a_addr_offset: assert property (@(posedge clk) disable iff (!rstn)
    req && ext_hit && !pend_q |=> ext_addr == $past(addr) - BASE)
    else $error("bad group offset"); // R05
  a_err_path: assert property (@(posedge clk) disable iff (!rstn)
    pend_q && ext_err && ERR_EN && OUTER && GRP == RGX_GRP_EXT |=> err)
    else $error("external error lost"); // R07
  a_int_no_ext: assert property (@(posedge clk) disable iff (!rstn)
    GRP == RGX_GRP_INT |-> !ext_ctl.req)
    else $error("internal group used external bus"); // R11
  a_int_ack: assert property (@(posedge clk) disable iff (!rstn)
    req && !pend_q && !ext_hit |=> ack ##1 !ack)
    else $error("internal access not acked"); // R12
  c_ext_write: cover property (@(posedge clk) ext_ctl.req && ext_ctl.wr);
  c_ext_read: cover property (@(posedge clk) ext_ctl.req && !ext_ctl.wr);
  c_err_seen: cover property (@(posedge clk) err);
endmodule : rgx_group

/* tb/rgx_ext_model.sv */
// Far-side model of the external members on the shared bus
`timescale 1ns/1ps
module rgx_ext_model
  import rgx_pkg::*;
(
  input  wire logic        clk,        // Bus clock
  input  rgx_ctl_t         ext_ctl,    // Shared control
  input  wire logic [2:0]  ext_sel,    // Member selects
  input  wire logic [31:0] ext_wdata,  // Shared write data
  output logic      [31:0] ext_rdata,  // Shared read data
  output logic             ext_err     // Error back to group
);
  logic [31:0] mem_q [3];
  logic [31:0] last_q = 32'h0000_0000;
  int          k;
  always_comb begin
    k = 0;
    for (int i = 0; i < 3; i++) if (ext_sel[i]) k = i;
  end
  // Idle bus shows the inverse of the last word, never a stale copy
  assign ext_rdata = ext_ctl.req ? mem_q[k] : ~last_q;
  assign ext_err   = 1'b0;
  initial for (int i = 0; i < 3; i++) mem_q[i] = 32'h0000_0000;
  always @(posedge clk) if (ext_ctl.req) begin
    last_q <= mem_q[k];
    if (ext_ctl.wr) mem_q[k] <= ext_wdata;
  end
endmodule : rgx_ext_model

/* tb/register_group_external_port_bench.sv */
// Random and corner accesses against the group and its external side
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module register_group_external_port_bench;
  import rgx_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, req = 1'b0, wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, ext_wdata, ext_rdata;
  logic        ack, err, ext_err;
  rgx_ctl_t    ext_ctl;
  logic [2:0]  ext_sel;
  logic [7:0]  ext_addr;
  logic [31:0] shadow [3] = '{default: 32'h0000_0000};
  int          error_cnt = 0, n_checks = 0;

  // Members 0 and 2 external, 1 internal: same reading from either end
  rgx_group #(.KIND(6'b01_00_01)) dut_u (.clk(clk), .rstn(rstn),
    .req(req), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata),
    .ack(ack), .err(err), .ext_ctl(ext_ctl), .ext_sel(ext_sel),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .ext_err(ext_err));
  rgx_ext_model far_u (.clk(clk), .ext_ctl(ext_ctl), .ext_sel(ext_sel),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_err(ext_err));

  initial forever #50 clk = ~clk;

  task automatic access(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
    int   m;
    logic bad, ex;
    m   = a[7:2];
    bad = a > 8'h08;
    ex  = !bad && m != 1;
    req <= 1'b1; wr <= w; addr <= a; wdata <= d;
    @(posedge clk) #1;
    req <= 1'b0;
    `CHK("ext_req", ex, ext_ctl.req)
    if (ex) begin
      `CHK("ext_wr", w, ext_ctl.wr)
      `CHK("ext_sel", 3'b001 << m, ext_sel)
      `CHK("ext_addr", a, ext_addr)
      `CHK("ext_wdata", d, ext_wdata)
      @(posedge clk) #1;
    end
    `CHK("ack", 1'b1, ack)
    `CHK("err", bad, err)
    if (!bad && !w) `CHK("rdata", shadow[m], rdata)
    if (!bad && w) shadow[m] = d;
    @(posedge clk) #1;
    `CHK("ack_low", 1'b0, ack)
  endtask : access

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  initial begin
    #(100 * 5000);
    error_cnt++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h27a369f0));
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    `CHK("ack_rst", 1'b0, ack)
    for (int i = 0; i < 3; i++) access(8'(i * 4), 1'b1, 32'hA5A5_0000 + i);
    for (int i = 2; i >= 0; i--) access(8'(i * 4), 1'b0, 32'h0000_0000);
    access(8'h0C, 1'b0, 32'h0000_0000);
    access(8'hFC, 1'b1, 32'hFFFF_FFFF);
    repeat (300)
      access(8'($urandom_range(0, 3) * 4), 1'($urandom), $urandom);
    stop_test();
  end
endmodule : register_group_external_port_bench
